// ### hw/pmsia_pkg.sv
package pmsia_pkg;

   // ==========================================================
   // management access request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  idx;
      logic [15:0] wdata;
   } pmsia_req_t;

   // ==========================================================
   // line conditions from the port logic
   typedef struct packed {
      logic an_done;
      logic far_fault;
      logic link_up;
   } pmsia_line_t;

   // ==========================================================
   // advertised abilities
   typedef struct packed {
      logic pause;
      logic fd100;
      logic hd100;
   } pmsia_adv_t;

endpackage : pmsia_pkg

// ### hw/pmsia_regs.svh
// Summary of operation
// - status bit 2 reads 1 while the link is up and 0 while it is down, resetting to 0.
// - status bit 5 reads 1 once auto-negotiation has finished and 0 before, resetting to 0.
// - status bit 4 reads 1 while a remote fault is detected and 0 otherwise, resetting to 0.
// - status bit 3 always reads 1 to show that auto-negotiation is supported.
// - status bit 0 always reads 0 to show that no extended register set exists.
// - register 2h returns the upper sixteen identifier bits, read-only.
// - register 3h returns the lower sixteen identifier bits, read-only.
// - advertisement register 4h has reserved bits 15 to 11 that read 0.
// - advertisement bit 10 is read/write pause capability and resets to 1.
// - advertisement bit 8 is read/write 100 Mbit/s full duplex and resets to 1.
// - advertisement bit 7 is read/write 100 Mbit/s half duplex and resets to 1.
`ifndef PMSIA_REGS_SVH
`define PMSIA_REGS_SVH

// ==========================================================
// register indices
`define PMSIA_IDX_STATUS      5'h01
`define PMSIA_IDX_ID_UPPER    5'h02
`define PMSIA_IDX_ID_LOWER    5'h03
`define PMSIA_IDX_ADVERT      5'h04

// ==========================================================
// status fields
`define PMSIA_ST_EXT_BIT      0
`define PMSIA_ST_LINK_BIT     2
`define PMSIA_ST_ANCAP_BIT    3
`define PMSIA_ST_FAULT_BIT    4
`define PMSIA_ST_ANDONE_BIT   5

// ==========================================================
// advertisement fields and resets
`define PMSIA_ADV_PAUSE_BIT   10
`define PMSIA_ADV_100FD_BIT   8
`define PMSIA_ADV_100HD_BIT   7
`define PMSIA_ADV_PAUSE_RST   1'h1
`define PMSIA_ADV_100FD_RST   1'h1
`define PMSIA_ADV_100HD_RST   1'h1
`define PMSIA_ADV_RSVD_MSB    15
`define PMSIA_ADV_RSVD_LSB    11

// ==========================================================
// input capture and read port
`define PMSIA_SYNC_STAGES     3
`define PMSIA_RD_DATA_RST     16'h0000

// ==========================================================
// identifier defaults, values arbitrary
`define PMSIA_ID_UPPER_DEF    16'hA5C3
`define PMSIA_ID_LOWER_DEF    16'h3C5A

`endif

// ### hw/pmsia_top.sv
`timescale 1ns/1ps
`include "pmsia_regs.svh"

module pmsia_top #(
   parameter logic [15:0] ID_UPPER    = `PMSIA_ID_UPPER_DEF,
   parameter logic [15:0] ID_LOWER    = `PMSIA_ID_LOWER_DEF,
   parameter int          SYNC_STAGES = `PMSIA_SYNC_STAGES
) (
   input  wire  logic                   clk_sys,
   input  wire  logic                   reset,
   input  wire  pmsia_pkg::pmsia_req_t  req,
   input  wire  pmsia_pkg::pmsia_line_t line_in,
   output logic [15:0]                  rd_data_q,
   output logic                         rd_valid_q,
   output pmsia_pkg::pmsia_adv_t        adv_q
);

   // ==========================================================
   // parameter and constant checks
   if (SYNC_STAGES != 3) begin : g_bad_sync
      $error("pmsia_top: SYNC_STAGES must be 3");
   end

   if (`PMSIA_ST_EXT_BIT > 15 || `PMSIA_ST_LINK_BIT > 15 ||
       `PMSIA_ST_ANCAP_BIT > 15 || `PMSIA_ST_FAULT_BIT > 15 ||
       `PMSIA_ST_ANDONE_BIT > 15) begin : g_bad_status_width
      $error("pmsia_top: status bit outside the word");
   end

   if (`PMSIA_ST_LINK_BIT == `PMSIA_ST_FAULT_BIT ||
       `PMSIA_ST_LINK_BIT == `PMSIA_ST_ANDONE_BIT ||
       `PMSIA_ST_FAULT_BIT == `PMSIA_ST_ANDONE_BIT) begin : g_bad_line_map
      $error("pmsia_top: status line bits overlap");
   end

   if (`PMSIA_ST_ANCAP_BIT == `PMSIA_ST_EXT_BIT ||
       `PMSIA_ST_ANCAP_BIT == `PMSIA_ST_LINK_BIT ||
       `PMSIA_ST_ANCAP_BIT == `PMSIA_ST_FAULT_BIT ||
       `PMSIA_ST_ANCAP_BIT == `PMSIA_ST_ANDONE_BIT) begin : g_bad_cap_map
      $error("pmsia_top: capability bit overlaps another status bit");
   end

   if (`PMSIA_ST_EXT_BIT == `PMSIA_ST_LINK_BIT ||
       `PMSIA_ST_EXT_BIT == `PMSIA_ST_FAULT_BIT ||
       `PMSIA_ST_EXT_BIT == `PMSIA_ST_ANDONE_BIT) begin : g_bad_ext_map
      $error("pmsia_top: extended bit overlaps a line bit");
   end

   if (`PMSIA_ADV_PAUSE_BIT == `PMSIA_ADV_100FD_BIT ||
       `PMSIA_ADV_PAUSE_BIT == `PMSIA_ADV_100HD_BIT ||
       `PMSIA_ADV_100FD_BIT == `PMSIA_ADV_100HD_BIT) begin : g_bad_adv_map
      $error("pmsia_top: advertisement bits overlap");
   end

   if (`PMSIA_ADV_RSVD_MSB != 15 ||
       `PMSIA_ADV_RSVD_LSB > `PMSIA_ADV_RSVD_MSB) begin : g_bad_rsvd_range
      $error("pmsia_top: reserved advertisement range must end at bit 15");
   end

   if (`PMSIA_ADV_PAUSE_BIT >= `PMSIA_ADV_RSVD_LSB ||
       `PMSIA_ADV_100FD_BIT >= `PMSIA_ADV_RSVD_LSB ||
       `PMSIA_ADV_100HD_BIT >= `PMSIA_ADV_RSVD_LSB) begin : g_bad_adv_rsvd
      $error("pmsia_top: advertisement bit inside the reserved range");
   end

   if (`PMSIA_IDX_STATUS == `PMSIA_IDX_ID_UPPER ||
       `PMSIA_IDX_STATUS == `PMSIA_IDX_ID_LOWER ||
       `PMSIA_IDX_STATUS == `PMSIA_IDX_ADVERT ||
       `PMSIA_IDX_ID_UPPER == `PMSIA_IDX_ID_LOWER ||
       `PMSIA_IDX_ID_UPPER == `PMSIA_IDX_ADVERT ||
       `PMSIA_IDX_ID_LOWER == `PMSIA_IDX_ADVERT) begin : g_bad_idx_map
      $error("pmsia_top: register indices overlap");
   end

   // ==========================================================
   // three-stage input capture
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [2:0] sync3_q;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         sync3_q <= 3'h0;
      end else begin
         sync1_q <= line_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // ==========================================================
   // change taken when stages 2 and 3 agree
   logic [2:0] line_q;

   genvar gi;
   for (gi = 0; gi < 3; gi++) begin : g_filt
      always_ff @(posedge clk_sys) begin
         if (reset) begin
            line_q[gi] <= 1'h0;
         end else if (sync2_q[gi] == sync3_q[gi]) begin
            line_q[gi] <= sync3_q[gi];
         end
      end
   end

   // ==========================================================
   // settled line conditions
   pmsia_pkg::pmsia_line_t line_s;
   logic                   link_up_s;
   logic                   far_fault_s;
   logic                   an_done_s;

   assign line_s      = line_q;
   assign link_up_s   = line_s.link_up;
   assign far_fault_s = line_s.far_fault;
   assign an_done_s   = line_s.an_done;

   // ==========================================================
   // status word
   logic [15:0] status_w;

   always_comb begin
      status_w                       = 16'h0000;
      status_w[`PMSIA_ST_LINK_BIT]   = link_up_s;
      status_w[`PMSIA_ST_ANDONE_BIT] = an_done_s;
      status_w[`PMSIA_ST_FAULT_BIT]  = far_fault_s;
      status_w[`PMSIA_ST_ANCAP_BIT]  = 1'h1;
      status_w[`PMSIA_ST_EXT_BIT]    = 1'h0;
   end

   // ==========================================================
   // identifier words, fixed at build time
   logic [15:0] id_upper_w;
   logic [15:0] id_lower_w;

   assign id_upper_w = ID_UPPER;
   assign id_lower_w = ID_LOWER;

   // ==========================================================
   // request fields
   logic rd_req;
   logic wr_req;

   assign rd_req = req.rd;
   assign wr_req = req.wr;

   // ==========================================================
   // index decode, shared by the read and write paths
   function automatic logic idx_hit(input logic [4:0] idx, input logic [4:0] want);
      return idx == want;
   endfunction : idx_hit

   logic hit_status;
   logic hit_id_upper;
   logic hit_id_lower;
   logic hit_advert;

   assign hit_status   = idx_hit(req.idx, `PMSIA_IDX_STATUS);
   assign hit_id_upper = idx_hit(req.idx, `PMSIA_IDX_ID_UPPER);
   assign hit_id_lower = idx_hit(req.idx, `PMSIA_IDX_ID_LOWER);
   assign hit_advert   = idx_hit(req.idx, `PMSIA_IDX_ADVERT);

   // ==========================================================
   // advertisement word, only bits 10, 8 and 7 are stored
   function automatic logic [15:0] adv_word(input pmsia_pkg::pmsia_adv_t a);
      logic [15:0] w;
      w                                           = 16'h0000;
      w[`PMSIA_ADV_RSVD_MSB:`PMSIA_ADV_RSVD_LSB] = '0;
      w[`PMSIA_ADV_PAUSE_BIT]                     = a.pause;
      w[`PMSIA_ADV_100FD_BIT]                     = a.fd100;
      w[`PMSIA_ADV_100HD_BIT]                     = a.hd100;
      return w;
   endfunction : adv_word

   // ==========================================================
   // write decode, only the advertisement word takes data
   logic                  adv_wr;
   pmsia_pkg::pmsia_adv_t adv_wdata;

   assign adv_wr    = wr_req && hit_advert;
   assign adv_wdata = {req.wdata[`PMSIA_ADV_PAUSE_BIT],
                       req.wdata[`PMSIA_ADV_100FD_BIT],
                       req.wdata[`PMSIA_ADV_100HD_BIT]};

   // ==========================================================
   // advertisement register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         adv_q.pause <= `PMSIA_ADV_PAUSE_RST;
         adv_q.fd100 <= `PMSIA_ADV_100FD_RST;
         adv_q.hd100 <= `PMSIA_ADV_100HD_RST;
      end else if (adv_wr) begin
         adv_q <= adv_wdata;
      end
   end

   // ==========================================================
   // read select, unmapped indices read zero
   logic [15:0] rd_mux;

   always_comb begin
      rd_mux = 16'h0000;
      if (hit_status) begin
         rd_mux = status_w;
      end else if (hit_id_upper) begin
         rd_mux = id_upper_w;
      end else if (hit_id_lower) begin
         rd_mux = id_lower_w;
      end else if (hit_advert) begin
         rd_mux = adv_word(adv_q);
      end
   end

   // ==========================================================
   // answer strobe, one cycle after each read
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rd_valid_q <= 1'h0;
      end else begin
         rd_valid_q <= rd_req;
      end
   end

   // ==========================================================
   // read data, holds until the next read
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rd_data_q <= `PMSIA_RD_DATA_RST;
      end else if (rd_req) begin
         rd_data_q <= rd_mux;
      end
   end

endmodule : pmsia_top

// ### verification/pmsia_chk_sva.sv
`timescale 1ns/1ps
module pmsia_chk #(
   parameter logic [15:0] ID_UPPER = 16'h0000,
   parameter logic [15:0] ID_LOWER = 16'h0000
) (
   input wire logic                   clk_sys,
   input wire logic                   reset,
   input wire pmsia_pkg::pmsia_req_t  req,
   input wire pmsia_pkg::pmsia_line_t line_in,
   input wire logic [15:0]            rd_data_q,
   input wire logic                   rd_valid_q,
   input wire pmsia_pkg::pmsia_adv_t  adv_q
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_rd_answer: assert property (req.rd |=> rd_valid_q)
      else $error("read not answered");
   a_no_spurious: assert property (!req.rd |=> !rd_valid_q)
      else $error("answer without read");
   a_id_upper: assert property (req.rd && req.idx == 5'h02 |=> rd_data_q == ID_UPPER)
      else $error("upper id wrong");
   a_id_lower: assert property (req.rd && req.idx == 5'h03 |=> rd_data_q == ID_LOWER)
      else $error("lower id wrong");
   a_status_fixed: assert property (req.rd && req.idx == 5'h01 |=> rd_data_q[3]
      && !rd_data_q[0]) else $error("status constant bits wrong");
   a_adv_read: assert property (req.rd && req.idx == 5'h04 |=> rd_data_q ==
      {5'h00, $past(adv_q[2]), 1'h0, $past(adv_q[1:0]), 7'h00}) else $error("adv read");
   a_adv_write: assert property (req.wr && req.idx == 5'h04 |=> adv_q ==
      {$past(req.wdata[10]), $past(req.wdata[8:7])}) else $error("adv not written");
   a_adv_hold: assert property (!(req.wr && req.idx == 5'h04) |=> $stable(adv_q))
      else $error("adv changed");
endmodule : pmsia_chk

bind pmsia_top pmsia_chk #(.ID_UPPER(ID_UPPER), .ID_LOWER(ID_LOWER)) u_chk (
   .clk_sys(clk_sys), .reset(reset), .req(req), .line_in(line_in),
   .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .adv_q(adv_q));

// ### verification/pmsia_mgr.sv
`timescale 1ns/1ps
module pmsia_mgr (
   input  wire logic            clk_sys,
   output pmsia_pkg::pmsia_req_t req
);
   initial req = '0;
   task automatic acc(input logic w, input logic [4:0] i, input logic [15:0] d);
      @(posedge clk_sys);
      #1 req = {w, !w, i, d};
      @(posedge clk_sys);
      #1 req = {2'h0, i, ~d};
   endtask : acc
endmodule : pmsia_mgr

// ### verification/pmsia_top_tb.sv
`timescale 1ns/1ps
module pmsia_top_tb;
   logic                   clk_sys = 1'h0;
   logic                   reset = 1'h1;
   pmsia_pkg::pmsia_line_t line_in = '0;
   pmsia_pkg::pmsia_req_t  req;
   logic [15:0]            rd_data_q;
   logic                   rd_valid_q;
   pmsia_pkg::pmsia_adv_t  adv_q;
   int                     n_fail = 0;
   int                     compares = 0;
   initial forever #2 clk_sys = ~clk_sys;
   pmsia_mgr mgr (.clk_sys(clk_sys), .req(req));
   pmsia_top #(.ID_UPPER(16'h5A96), .ID_LOWER(16'h0F1E)) dut (.clk_sys(clk_sys),
      .reset(reset), .req(req), .line_in(line_in), .rd_data_q(rd_data_q),
      .rd_valid_q(rd_valid_q), .adv_q(adv_q));
   task automatic rd(input logic [4:0] i, input logic [15:0] e);
      mgr.acc(1'h0, i, 16'h0000);
      compares += 2;
      if (rd_valid_q !== 1'h1 || rd_data_q !== e) begin
         n_fail++;
         $display("MISMATCH reg %h exp %h got %h valid %b", i, e, rd_data_q, rd_valid_q);
      end
   endtask : rd
   task automatic chk_adv(input pmsia_pkg::pmsia_adv_t e);
      compares++;
      if (adv_q !== e) begin
         n_fail++;
         $display("MISMATCH adv_q exp %b got %b", e, adv_q);
      end
   endtask : chk_adv
   task wrap_up;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up
   initial begin
      #10000;
      n_fail++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      #1 reset = 1'h0;
      chk_adv(3'h7);
      rd(5'h04, 16'h0580);
      rd(5'h01, 16'h0008);
      rd(5'h02, 16'h5A96);
      rd(5'h03, 16'h0F1E);
      rd(5'h1F, 16'h0000);
      for (int i = 1; i < 4; i++) mgr.acc(1'h1, 5'(i), 16'hFFFF);
      rd(5'h01, 16'h0008);
      rd(5'h02, 16'h5A96);
      rd(5'h03, 16'h0F1E);
      mgr.acc(1'h1, 5'h04, 16'hFFFF);
      chk_adv(3'h7);
      rd(5'h04, 16'h0580);
      mgr.acc(1'h1, 5'h04, 16'h0000);
      chk_adv(3'h0);
      rd(5'h04, 16'h0000);
      for (int l = 0; l < 8; l++) begin
         line_in = 3'(l);
         repeat (6) @(posedge clk_sys);
         rd(5'h01, {10'h000, line_in.an_done, line_in.far_fault, 1'h1,
            line_in.link_up, 2'h0});
      end
      line_in = '0;
      @(posedge clk_sys);
      #1 reset = 1'h1;
      repeat (2) @(posedge clk_sys);
      #1 reset = 1'h0;
      chk_adv(3'h7);
      rd(5'h04, 16'h0580);
      rd(5'h01, 16'h0008);
      wrap_up();
   end
endmodule : pmsia_top_tb
